// ==== common/cmsf_pkg.sv ====
// Package for the memory scan fetch block: register map, fields, reset values
// Assumes a 32-bit APB slave with one aligned word per register
package cmsf_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_ADDR_LOW = 12'h004;
  localparam logic [11:0] OFS_ADDR_HIGH = 12'h008;
  localparam logic [11:0] OFS_ADDR_UPPER = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  // ---------------------------------------------------------------------------
  // Fields
  // ---------------------------------------------------------------------------
  localparam int CTL_GO_BIT = 0;
  localparam int CTL_TRIG_BIT = 1;
  localparam int CTL_BURST_BIT = 2;
  localparam int ADDR_W = 22;
  localparam int UPPER_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
  } cmsf_word_t;
endpackage : cmsf_pkg

// ==== rtl/cmsf_top.sv ====
// Memory scan fetch engine feeding a CRC unit, with an APB register slave
// Assumes arbiter grants are synchronous to pclk; read data arrive with the grant
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - No gating, no burst: request only while CRC side can accept a word.
// - Gating on, no burst: request needs CRC side able to accept a word and trigger true together.
// - Burst on: request while scanning, except in the cycle after a fetch, ignoring trigger and readiness.
// - After every fetch the pointer advances to the next location.
// - 22-bit pointer; upper byte holds bits 21:16, bits 7:6 read zero.
// - High byte holds bits 15:8; pointer bytes reset to zero.
// - Pointer byte writes are ignored while the scan is in progress.
module cmsf_top import cmsf_pkg::*; (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              scan_trigger,
  output logic                   mem_req,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_grant,
  input  wire logic [31:0]       mem_rdata,
  output logic                   crc_valid,
  output cmsf_word_t             crc_word,
  input  wire logic              crc_ready
);
  // ---------------------------------------------------------------------------
  // Registers and buffer state
  // ---------------------------------------------------------------------------
  logic              scan_in_progress;
  logic              trigger_gate_enable;
  logic              burst_fetch_mode;
  logic [ADDR_W-1:0] current_fetch_address;
  cmsf_word_t        buf_mem [2];
  logic              buf_wp;
  logic              buf_rp;
  logic [1:0]        buf_cnt;
  logic [31:0]       next_prdata;
  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  wire logic access_w   = psel & penable;
  wire logic wr_w       = access_w & pwrite;
  wire logic rd_w       = access_w & ~pwrite;
  wire logic hit_ctl    = paddr == OFS_CONTROL;
  wire logic hit_low    = paddr == OFS_ADDR_LOW;
  wire logic hit_high   = paddr == OFS_ADDR_HIGH;
  wire logic hit_upper  = paddr == OFS_ADDR_UPPER;
  wire logic hit_stat   = paddr == OFS_STATUS;
  wire logic mapped_w   = hit_ctl | hit_low | hit_high | hit_upper | hit_stat;
  wire logic ptr_wr_ok  = wr_w & ~scan_in_progress;
  // ---------------------------------------------------------------------------
  // Fetch request and buffer
  // ---------------------------------------------------------------------------
  wire logic buf_full   = buf_cnt == BUF_DEPTH;
  wire logic buf_empty  = buf_cnt == 2'h0;
  wire logic accept_w   = ~buf_full;
  wire logic gate_ok    = ~trigger_gate_enable | scan_trigger;
  wire logic next_req   = scan_in_progress & (burst_fetch_mode | (accept_w & gate_ok));
  wire logic fetch_w    = mem_req & mem_grant & accept_w;
  wire logic drain_w    = crc_valid & crc_ready;
  wire logic pop_w      = ~buf_empty & (~crc_valid | crc_ready);

  always_comb begin
    next_prdata = READ_ZERO;
    if (hit_ctl) begin
      next_prdata[CTL_GO_BIT]    = scan_in_progress;
      next_prdata[CTL_TRIG_BIT]  = trigger_gate_enable;
      next_prdata[CTL_BURST_BIT] = burst_fetch_mode;
    end else if (hit_low) begin
      next_prdata[7:0] = current_fetch_address[7:0];
    end else if (hit_high) begin
      next_prdata[7:0] = current_fetch_address[15:8];
    end else if (hit_upper) begin
      next_prdata[UPPER_W-1:0] = current_fetch_address[ADDR_W-1:16];
    end else if (hit_stat) begin
      next_prdata[1:0] = buf_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= READ_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped_w;
      if (psel & ~penable & ~pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  wire logic wr_take = wr_w & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_in_progress    <= 1'b0;
      trigger_gate_enable <= 1'b0;
      burst_fetch_mode    <= 1'b0;
    end else if (wr_take & hit_ctl) begin
      scan_in_progress    <= pwdata[CTL_GO_BIT];
      trigger_gate_enable <= pwdata[CTL_TRIG_BIT];
      burst_fetch_mode    <= pwdata[CTL_BURST_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Pointer
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_fetch_address <= ADDR_RESET;
    end else if (fetch_w) begin
      current_fetch_address <= current_fetch_address + 22'h000001;
    end else if (ptr_wr_ok & pready & hit_low) begin
      current_fetch_address[7:0] <= pwdata[7:0];
    end else if (ptr_wr_ok & pready & hit_high) begin
      current_fetch_address[15:8] <= pwdata[7:0];
    end else if (ptr_wr_ok & pready & hit_upper) begin
      current_fetch_address[ADDR_W-1:16] <= pwdata[UPPER_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req  <= 1'b0;
      mem_addr <= ADDR_RESET;
    end else begin
      mem_req  <= next_req & ~fetch_w;
      mem_addr <= fetch_w ? current_fetch_address + 22'h000001 : current_fetch_address;
    end
  end

  // ---------------------------------------------------------------------------
  // Two-entry buffer towards the CRC unit
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (fetch_w) begin
      buf_mem[buf_wp] <= '{addr: mem_addr, data: mem_rdata};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wp    <= 1'b0;
      buf_rp    <= 1'b0;
      buf_cnt   <= 2'h0;
      crc_valid <= 1'b0;
      crc_word  <= '0;
    end else begin
      if (fetch_w) begin
        buf_wp <= ~buf_wp;
      end
      if (pop_w) begin
        buf_rp   <= ~buf_rp;
        crc_word <= buf_mem[buf_rp];
      end
      if (pop_w) begin
        crc_valid <= 1'b1;
      end else if (drain_w) begin
        crc_valid <= 1'b0;
      end
      buf_cnt <= buf_cnt + {1'b0, fetch_w} - {1'b0, pop_w};
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  lock_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    (scan_in_progress && !fetch_w && $past(scan_in_progress)) |=> 1'b1 ##0
    (current_fetch_address == $past(current_fetch_address) || $past(fetch_w)))
    else $error("Pointer changed while locked without a fetch");
  ptr_step_a : assert property (@(posedge pclk) disable iff (!presetn)
    fetch_w |=> current_fetch_address == $past(current_fetch_address) + 22'h000001)
    else $error("Pointer did not step after fetch");
  burst_req_a : assert property (@(posedge pclk) disable iff (!presetn)
    (scan_in_progress && burst_fetch_mode && !fetch_w) |=> mem_req)
    else $error("Burst mode dropped the request");
  idle_req_a : assert property (@(posedge pclk) disable iff (!presetn)
    (!burst_fetch_mode && buf_full) |=> !mem_req)
    else $error("Request raised while CRC side full");
  gate_req_a : assert property (@(posedge pclk) disable iff (!presetn)
    (trigger_gate_enable && !burst_fetch_mode && !scan_trigger) |=> !mem_req)
    else $error("Gated request without trigger");
  upper_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) && !pwrite && hit_upper |-> prdata[31:UPPER_W] == 26'h0000000)
    else $error("Upper byte spare bits not zero");
  buf_bound_a : assert property (@(posedge pclk) disable iff (!presetn)
    buf_cnt <= BUF_DEPTH)
    else $error("Buffer overfilled");
  low_lock_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_low && scan_in_progress && !fetch_w) |=>
    current_fetch_address[7:0] == $past(current_fetch_address[7:0]))
    else $error("Low byte written while locked");

  // ---------------------------------------------------------------------------
  // Further checks
  // ---------------------------------------------------------------------------
  req_no_scan_a : assert property (@(posedge pclk) disable iff (!presetn)
    !scan_in_progress |=>
    !mem_req)
    else $error("Request raised while scan idle");
  fetch_drop_a : assert property (@(posedge pclk) disable iff (!presetn)
    fetch_w |=>
    !mem_req)
    else $error("Request held after fetch");
  addr_follow_a : assert property (@(posedge pclk) disable iff (!presetn)
    fetch_w |=>
    mem_addr == $past(current_fetch_address) + 22'h000001)
    else $error("Fetch address did not advance");
  addr_track_a : assert property (@(posedge pclk) disable iff (!presetn)
    !fetch_w |=>
    mem_addr == $past(current_fetch_address))
    else $error("Fetch address does not follow pointer");
  plain_req_a : assert property (@(posedge pclk) disable iff (!presetn)
    (scan_in_progress && !trigger_gate_enable && !burst_fetch_mode && !buf_full && !fetch_w) |=>
    mem_req)
    else $error("Ungated request missing");
  gate_fire_a : assert property (@(posedge pclk) disable iff (!presetn)
    (scan_in_progress && trigger_gate_enable && !burst_fetch_mode && scan_trigger && !buf_full && !fetch_w) |=>
    mem_req)
    else $error("Triggered request missing");
  burst_full_a : assert property (@(posedge pclk) disable iff (!presetn)
    (scan_in_progress && burst_fetch_mode && buf_full && !fetch_w) |=>
    mem_req)
    else $error("Burst request dropped while full");
  high_spare_a : assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pready) && !pwrite && hit_high) |->
    prdata[31:8] == 24'h000000)
    else $error("High byte spare bits not zero");
  high_rdata_a : assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pready) && !pwrite && hit_high) |->
    prdata[7:0] == $past(current_fetch_address[15:8]))
    else $error("High byte read wrong");
  low_spare_a : assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pready) && !pwrite && hit_low) |->
    prdata[31:8] == 24'h000000)
    else $error("Low byte spare bits not zero");
  low_rdata_a : assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pready) && !pwrite && hit_low) |->
    prdata[7:0] == $past(current_fetch_address[7:0]))
    else $error("Low byte read wrong");
  upper_rdata_a : assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pready) && !pwrite && hit_upper) |->
    prdata[UPPER_W-1:0] == $past(current_fetch_address[ADDR_W-1:16]))
    else $error("Upper byte read wrong");
  high_lock_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_high && scan_in_progress && !fetch_w) |=>
    current_fetch_address[15:8] == $past(current_fetch_address[15:8]))
    else $error("High byte written while locked");
  upper_lock_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_upper && scan_in_progress && !fetch_w) |=>
    current_fetch_address[ADDR_W-1:16] == $past(current_fetch_address[ADDR_W-1:16]))
    else $error("Upper byte written while locked");
  no_move_a : assert property (@(posedge pclk) disable iff (!presetn)
    (!fetch_w && !wr_take) |=>
    current_fetch_address == $past(current_fetch_address))
    else $error("Pointer moved without fetch or write");
  high_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_high && !scan_in_progress && !fetch_w) |=>
    current_fetch_address[15:8] == $past(pwdata[7:0]))
    else $error("High byte write lost");
  upper_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_upper && !scan_in_progress && !fetch_w) |=>
    current_fetch_address[ADDR_W-1:16] == $past(pwdata[UPPER_W-1:0]))
    else $error("Upper byte write lost");
  low_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_low && !scan_in_progress && !fetch_w) |=>
    current_fetch_address[7:0] == $past(pwdata[7:0]))
    else $error("Low byte write lost");
  go_ctl_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_ctl) |=>
    scan_in_progress == $past(pwdata[CTL_GO_BIT]))
    else $error("Scan bit write lost");
  trig_ctl_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_ctl) |=>
    trigger_gate_enable == $past(pwdata[CTL_TRIG_BIT]))
    else $error("Gating bit write lost");
  burst_ctl_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && hit_ctl) |=>
    burst_fetch_mode == $past(pwdata[CTL_BURST_BIT]))
    else $error("Burst bit write lost");
  valid_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    (crc_valid && !crc_ready) |=>
    (crc_valid && $stable(crc_word)))
    else $error("Word dropped while CRC side stalled");
  cnt_fill_a : assert property (@(posedge pclk) disable iff (!presetn)
    (fetch_w && !pop_w) |=>
    buf_cnt == $past(buf_cnt) + 2'h1)
    else $error("Buffer count did not rise");
  cnt_drain_a : assert property (@(posedge pclk) disable iff (!presetn)
    (!fetch_w && pop_w) |=>
    buf_cnt == $past(buf_cnt) - 2'h1)
    else $error("Buffer count did not fall");
  word_take_a : assert property (@(posedge pclk) disable iff (!presetn)
    pop_w |=>
    crc_word == $past(buf_mem[buf_rp]))
    else $error("Wrong word handed to CRC side");
  valid_set_a : assert property (@(posedge pclk) disable iff (!presetn)
    pop_w |=>
    crc_valid)
    else $error("Word not presented after pop");
  valid_clr_a : assert property (@(posedge pclk) disable iff (!presetn)
    (drain_w && !pop_w) |=>
    !crc_valid)
    else $error("Valid held after last word taken");
endmodule : cmsf_top

// ==== test/cmsf_partner.sv ====
// Far side model: arbiter with busier masters, memory and CRC sink
// Assumes the scanner samples grant and data at rising pclk edges
`timescale 1ns/1ps
module cmsf_partner import cmsf_pkg::*; (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              stall_crc,
  input  wire logic              mem_req,
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic                   mem_grant,
  output logic      [31:0]       mem_rdata,
  output logic                   crc_ready
);
  integer      seed = 43;
  logic [31:0] rnd;
  // Data only valid with the grant; otherwise noise
  assign mem_rdata = mem_grant ? {~mem_addr[9:0], mem_addr} : rnd;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd       <= 32'h00000000;
      mem_grant <= 1'b0;
      crc_ready <= 1'b0;
    end else begin
      rnd       <= $random(seed);
      mem_grant <= mem_req && rnd[1:0] != 2'h0;
      crc_ready <= !stall_crc && rnd[2];
    end
  end
endmodule : cmsf_partner

// ==== test/crc_memory_scan_fetch_tb.sv ====
// Testbench for the memory scan fetch block: registers, modes, stream
// Assumes the partner returns {~addr[9:0], addr} as memory data
`timescale 1ns/1ps
module crc_memory_scan_fetch_tb import cmsf_pkg::*;;
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h00000000, prdata, mem_rdata, rd_val, rnd32;
  logic              pready, pslverr, err, mem_req, mem_grant, crc_valid, crc_ready;
  logic              scan_trigger = 1'b0, stall_crc = 1'b0, trig_on = 1'b0;
  logic [ADDR_W-1:0] mem_addr, ptr;
  cmsf_word_t        crc_word;
  cmsf_word_t        exp_q[$];
  integer            seed = 43, error_cnt = 0, n_tests = 0, got = 0, n;
  always #10 pclk = ~pclk;
  always @(posedge pclk) scan_trigger <= trig_on && ($random(seed) & 1) != 0;
  cmsf_top u_cmsf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scan_trigger(scan_trigger), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_grant(mem_grant), .mem_rdata(mem_rdata), .crc_valid(crc_valid), .crc_word(crc_word),
    .crc_ready(crc_ready));
  cmsf_partner u_cmsf_partner (.pclk(pclk), .presetn(presetn), .stall_crc(stall_crc),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_grant(mem_grant), .mem_rdata(mem_rdata),
    .crc_ready(crc_ready));
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd_val = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h00000000);
    chk("prdata", {56'h0, e}, {32'h0, rd_val});
  endtask : rd
  task automatic scan(input logic [2:0] ctl, input logic [ADDR_W-1:0] b);
    integer            i;
    logic [ADDR_W-1:0] a;
    apb(1'b1, OFS_ADDR_LOW, {24'h0, b[7:0]});
    apb(1'b1, OFS_ADDR_HIGH, {24'h0, b[15:8]});
    apb(1'b1, OFS_ADDR_UPPER, {26'h0, b[21:16]});
    for (i = 0; i < 4; i++) begin
      a = b + i[ADDR_W-1:0];
      exp_q.push_back({a, ~a[9:0], a});
    end
    stall_crc <= 1'b1;
    trig_on   <= 1'b0;
    got = 0;
    apb(1'b1, OFS_CONTROL, {29'h0, ctl});
    repeat (40) @(posedge pclk);
    chk("mem_req", {63'h0, ctl[CTL_BURST_BIT]}, {63'h0, mem_req});
    apb(1'b1, OFS_ADDR_LOW, 32'h000000A5);
    stall_crc <= 1'b0;
    trig_on   <= 1'b1;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge pclk);
    apb(1'b1, OFS_CONTROL, 32'h00000000);
    repeat (3) @(posedge pclk);
    for (i = 0; i < 100 && crc_valid !== 1'b0; i++) @(posedge pclk);
    ptr = b + got[ADDR_W-1:0];
    rd(OFS_ADDR_LOW, ptr[7:0]);
    rd(OFS_ADDR_HIGH, ptr[15:8]);
    rd(OFS_ADDR_UPPER, {2'h0, ptr[21:16]});
  endtask : scan
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Stream watcher: oldest note against each word handed over
  always @(posedge pclk) begin
    if (presetn && crc_valid === 1'b1 && crc_ready === 1'b1) begin
      got++;
      if (exp_q.size() > 0) chk("crc_word", {10'h0, exp_q.pop_front()}, {10'h0, crc_word});
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_ADDR_HIGH, 8'h00);
    rd(OFS_ADDR_UPPER, 8'h00);
    rd(OFS_ADDR_LOW, 8'h00);
    apb(1'b1, OFS_ADDR_UPPER, 32'h000000FF);
    rd(OFS_ADDR_UPPER, 8'h3F);
    apb(1'b0, 12'h014, 32'h00000000);
    chk("pslverr", 64'h1, {63'h0, err});
    for (n = 0; n < 8; n++) begin
      rnd32 = $random(seed);
      scan({n[1], n[0], 1'b1}, n == 0 ? 22'h3FFFFD : n == 1 ? 22'h00FFFE : rnd32[ADDR_W-1:0]);
    end
    print_verdict();
  end
endmodule : crc_memory_scan_fetch_tb
